// File: xae_defs.vh
// constants for the xdata address extension and fast port block
`ifndef XAE_DEFS_VH
`define XAE_DEFS_VH
// special register addresses
`define XAE_SFR_DPL0      8'h82
`define XAE_SFR_DPH0      8'h83
`define XAE_SFR_DPL1      8'h84
`define XAE_SFR_DPH1      8'h85
`define XAE_SFR_DPSEL     8'h86
`define XAE_SFR_PX0       8'h93
`define XAE_SFR_PX1       8'h95
`define XAE_SFR_IMID      8'ha0
`define XAE_SFR_IHIGH     8'hea
// fast port slots: data, pin state, select per port
`define XAE_NPORT         9
`define XAE_PORT_DR_LIST  72'hf8_e8_d8_c8_c0_b0_98_90_80
`define XAE_PORT_PS_LIST  72'hf9_e9_d9_c9_c1_b1_99_91_89
`define XAE_PORT_SEL_LIST 72'hfa_f2_da_ca_c2_b2_9a_a2_8a
// reset values
`define XAE_RST_BYTE      8'h00
`define XAE_RST_WORD      16'h0000
// xdata move modes
`define XAE_MODE_DPTR     1'b0
`define XAE_MODE_RI       1'b1
// xdata region limits (24-bit)
`define XAE_SRAM_LO       24'h000000
`define XAE_SRAM_HI       24'h001fff
`define XAE_INTC_LO       24'h004400
`define XAE_INTC_HI       24'h0044ff
`define XAE_PORT_LO       24'h005000
`define XAE_PORT_HI       24'h0051ff
`define XAE_EEP_LO        24'h008000
`define XAE_EEP_HI        24'h008fff
`define XAE_ECC_LO        24'h080000
`define XAE_ECC_HI        24'h081fff
`endif

// File: xae_fast_port.v
// one port with fast special register access: data, source select, pin state
`timescale 1ns/100ps
`include "xae_defs.vh"
module xae_fast_port #(
  parameter [7:0] DR_ADDR  = 8'h80,
  parameter [7:0] PS_ADDR  = 8'h89,
  parameter [7:0] SEL_ADDR = 8'h8a
) (
  // clock and reset
  input  wire       sys_clk,
  input  wire       sys_rst,
  // special register bus
  input  wire [7:0] sfr_addr,
  input  wire       sfr_wr,
  input  wire [7:0] sfr_wdata,
  // pins and hub side
  input  wire [7:0] hub_port_output_data,
  input  wire [7:0] pin_in,
  output wire [7:0] pin_out,
  // read back
  output reg  [7:0] rd_data,
  output wire       rd_hit
);
  reg [7:0] fast_port_output_data_q;
  reg [7:0] fast_port_output_source_select_q;
  reg [7:0] fast_port_pin_state_q;

  ////////////////////////////////////////////////////////////////
  // writable registers; pin state ignores writes
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      fast_port_output_data_q          <= `XAE_RST_BYTE;
      fast_port_output_source_select_q <= `XAE_RST_BYTE;
      fast_port_pin_state_q            <= `XAE_RST_BYTE;
    end else begin
      if (sfr_wr && sfr_addr == DR_ADDR)
        fast_port_output_data_q <= sfr_wdata; // RULE_06
      if (sfr_wr && sfr_addr == SEL_ADDR)
        fast_port_output_source_select_q <= sfr_wdata;
      fast_port_pin_state_q <= pin_in; // RULE_09
    end
  end

  // per-pin source mux
  genvar y;
  generate
    for (y = 0; y < 8; y = y + 1) begin : g_pin
      assign pin_out[y] = fast_port_output_source_select_q[y]
                        ? fast_port_output_data_q[y]   // RULE_07
                        : hub_port_output_data[y];     // RULE_08
    end
  endgenerate

  // read mux
  assign rd_hit = (sfr_addr == DR_ADDR) || (sfr_addr == PS_ADDR) || (sfr_addr == SEL_ADDR);
  always @* begin
    rd_data = `XAE_RST_BYTE;
    if (sfr_addr == DR_ADDR)
      rd_data = fast_port_output_data_q;
    else if (sfr_addr == PS_ADDR)
      rd_data = fast_port_pin_state_q; // RULE_09
    else if (sfr_addr == SEL_ADDR)
      rd_data = fast_port_output_source_select_q;
  end
endmodule // xae_fast_port

// File: xae_xdata_ext.v
// xdata address extension, region decode and fast port special registers
`timescale 1ns/100ps
`include "xae_defs.vh"
// Overview of operation
// RULE_01: extension registers only shape xdata move addresses
// RULE_02: pointer moves take high byte from pointer extension
// RULE_03: R0/R1 moves take high, middle from extensions
// RULE_04: pointer select picks pointer for all users
// RULE_05: low bits from pointer or from R0/R1
// RULE_06: each fast port holds output data register
// RULE_07: select bit set drives pin from fast data
// RULE_08: select bit clear drives pin from hub data
// RULE_09: pin state register is read only
// RULE_10: hub keeps full access to port registers
// RULE_11: xdata address is 24 bits, 16 MB
// RULE_12: lowest region decodes to on-chip SRAM
// RULE_13: port control region decodes to port registers
// RULE_14: interrupt controller region decodes to controller
// RULE_15: nonvolatile data region decodes to EEPROM
// RULE_16: ECC storage region decodes to flash ECC
module xae_xdata_ext #(
  parameter NPORT = `XAE_NPORT
) (
  // clock and reset
  input  wire               sys_clk,
  input  wire               sys_rst,
  // special register bus
  input  wire [7:0]         sfr_addr,
  input  wire               sfr_wr,
  input  wire [7:0]         sfr_wdata,
  output reg  [7:0]         sfr_rdata,
  output wire               sfr_hit,
  // core pointer operations
  input  wire               dptr_load,
  input  wire [15:0]        dptr_load_val,
  input  wire               dptr_inc,
  output wire [15:0]        sel_dptr,
  // xdata move request
  input  wire               xmov_en,
  input  wire               xmov_mode,
  input  wire [7:0]         xmov_ri,
  output reg  [23:0]        xdata_addr,
  output reg                xdata_valid,
  // region selects
  output reg                sel_sram,
  output reg                sel_intc,
  output reg                sel_port,
  output reg                sel_eeprom,
  output reg                sel_ecc,
  output reg                sel_other,
  // ports: hub data in, pins in, pins out, 8 bits per port
  input  wire [NPORT*8-1:0] hub_port_output_data,
  input  wire [NPORT*8-1:0] pin_in,
  output wire [NPORT*8-1:0] pin_out
);
  reg  [15:0] first_data_pointer_q;
  reg  [15:0] second_data_pointer_q;
  reg         data_pointer_select_q;
  reg  [7:0]  pointer0_high_extension_q;
  reg  [7:0]  pointer1_high_extension_q;
  reg  [7:0]  indirect_high_extension_q;
  reg  [7:0]  indirect_middle_extension_q;
  reg  [23:0] addr_d;
  reg  [7:0]  core_rdata;
  reg         core_hit;
  reg  [7:0]  port_rdata;
  reg         port_hit_any;
  integer     k;
  wire [NPORT*8-1:0] prt_rdata;
  wire [NPORT-1:0]   prt_hit;
  // per-port slot addresses, one byte each, port 0 in the low byte
  localparam [`XAE_NPORT*8-1:0] DR_LIST  = `XAE_PORT_DR_LIST;
  localparam [`XAE_NPORT*8-1:0] PS_LIST  = `XAE_PORT_PS_LIST;
  localparam [`XAE_NPORT*8-1:0] SEL_LIST = `XAE_PORT_SEL_LIST;
  wire [15:0] dptr_sum;

  ////////////////////////////////////////////////////////////////
  // selected pointer seen by table reads, jumps and moves
  assign sel_dptr = data_pointer_select_q ? second_data_pointer_q
                                          : first_data_pointer_q; // RULE_04
  assign dptr_sum = sel_dptr + 16'h0001;

  // pointer and extension registers
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      first_data_pointer_q        <= `XAE_RST_WORD;
      second_data_pointer_q       <= `XAE_RST_WORD;
      data_pointer_select_q       <= 1'b0;
      pointer0_high_extension_q   <= `XAE_RST_BYTE;
      pointer1_high_extension_q   <= `XAE_RST_BYTE;
      indirect_high_extension_q   <= `XAE_RST_BYTE;
      indirect_middle_extension_q <= `XAE_RST_BYTE;
    end else begin
      if (sfr_wr) begin
        case (sfr_addr)
          `XAE_SFR_DPL0:  first_data_pointer_q[7:0]   <= sfr_wdata;
          `XAE_SFR_DPH0:  first_data_pointer_q[15:8]  <= sfr_wdata;
          `XAE_SFR_DPL1:  second_data_pointer_q[7:0]  <= sfr_wdata;
          `XAE_SFR_DPH1:  second_data_pointer_q[15:8] <= sfr_wdata;
          `XAE_SFR_DPSEL: data_pointer_select_q       <= sfr_wdata[0];
          `XAE_SFR_PX0:   pointer0_high_extension_q   <= sfr_wdata;
          `XAE_SFR_PX1:   pointer1_high_extension_q   <= sfr_wdata;
          `XAE_SFR_IHIGH: indirect_high_extension_q   <= sfr_wdata;
          `XAE_SFR_IMID:  indirect_middle_extension_q <= sfr_wdata;
          default: ;
        endcase
      end
      // core load or increment acts on the selected pointer only
      if (dptr_load || dptr_inc) begin
        if (data_pointer_select_q)
          second_data_pointer_q <= dptr_load ? dptr_load_val : dptr_sum; // RULE_04
        else
          first_data_pointer_q <= dptr_load ? dptr_load_val : dptr_sum; // RULE_04
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // 24-bit address build, used only for xdata moves
  always @* begin
    addr_d = 24'h000000;
    if (xmov_mode == `XAE_MODE_DPTR)
      addr_d = {(data_pointer_select_q ? pointer1_high_extension_q
                                       : pointer0_high_extension_q), // RULE_02
                sel_dptr};                                          // RULE_05
    else
      addr_d = {indirect_high_extension_q, indirect_middle_extension_q, // RULE_03
                xmov_ri};                                              // RULE_05
  end

  // address and region decode registered on a move request
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      xdata_addr  <= 24'h000000;
      xdata_valid <= 1'b0;
      sel_sram    <= 1'b0;
      sel_intc    <= 1'b0;
      sel_port    <= 1'b0;
      sel_eeprom  <= 1'b0;
      sel_ecc     <= 1'b0;
      sel_other   <= 1'b0;
    end else begin
      xdata_valid <= xmov_en; // RULE_01
      if (xmov_en) begin
        xdata_addr <= addr_d; // RULE_11
        sel_sram   <= (addr_d <= `XAE_SRAM_HI); // RULE_12
        sel_intc   <= (addr_d >= `XAE_INTC_LO) && (addr_d <= `XAE_INTC_HI); // RULE_14
        sel_port   <= (addr_d >= `XAE_PORT_LO) && (addr_d <= `XAE_PORT_HI); // RULE_13
        sel_eeprom <= (addr_d >= `XAE_EEP_LO) && (addr_d <= `XAE_EEP_HI); // RULE_15
        sel_ecc    <= (addr_d >= `XAE_ECC_LO) && (addr_d <= `XAE_ECC_HI); // RULE_16
        sel_other  <= !((addr_d <= `XAE_SRAM_HI) ||
                        ((addr_d >= `XAE_INTC_LO) && (addr_d <= `XAE_INTC_HI)) ||
                        ((addr_d >= `XAE_PORT_LO) && (addr_d <= `XAE_PORT_HI)) ||
                        ((addr_d >= `XAE_EEP_LO) && (addr_d <= `XAE_EEP_HI)) ||
                        ((addr_d >= `XAE_ECC_LO) && (addr_d <= `XAE_ECC_HI)));
      end else begin
        sel_sram   <= 1'b0;
        sel_intc   <= 1'b0;
        sel_port   <= 1'b0;
        sel_eeprom <= 1'b0;
        sel_ecc    <= 1'b0;
        sel_other  <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // fast port instances; hub data stays an input so hub access remains
  genvar p;
  generate
    for (p = 0; p < NPORT; p = p + 1) begin : g_port
      xae_fast_port #(
        .DR_ADDR  (DR_LIST[8*p +: 8]),
        .PS_ADDR  (PS_LIST[8*p +: 8]),
        .SEL_ADDR (SEL_LIST[8*p +: 8])
      ) u_port (
        .sys_clk              (sys_clk),
        .sys_rst              (sys_rst),
        .sfr_addr             (sfr_addr),
        .sfr_wr               (sfr_wr),
        .sfr_wdata            (sfr_wdata),
        .hub_port_output_data (hub_port_output_data[8*p+7:8*p]), // RULE_10
        .pin_in               (pin_in[8*p+7:8*p]),
        .pin_out              (pin_out[8*p+7:8*p]),
        .rd_data              (prt_rdata[8*p+7:8*p]),
        .rd_hit               (prt_hit[p])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // read mux for core registers
  always @* begin
    core_hit   = 1'b1;
    core_rdata = `XAE_RST_BYTE;
    case (sfr_addr)
      `XAE_SFR_DPL0:  core_rdata = first_data_pointer_q[7:0];
      `XAE_SFR_DPH0:  core_rdata = first_data_pointer_q[15:8];
      `XAE_SFR_DPL1:  core_rdata = second_data_pointer_q[7:0];
      `XAE_SFR_DPH1:  core_rdata = second_data_pointer_q[15:8];
      `XAE_SFR_DPSEL: core_rdata = {7'h00, data_pointer_select_q};
      `XAE_SFR_PX0:   core_rdata = pointer0_high_extension_q;
      `XAE_SFR_PX1:   core_rdata = pointer1_high_extension_q;
      `XAE_SFR_IHIGH: core_rdata = indirect_high_extension_q;
      `XAE_SFR_IMID:  core_rdata = indirect_middle_extension_q;
      default:        core_hit   = 1'b0;
    endcase
  end

  // merge port read data; unmapped addresses read zero
  always @* begin
    port_rdata   = `XAE_RST_BYTE;
    port_hit_any = 1'b0;
    for (k = 0; k < NPORT; k = k + 1) begin
      port_rdata   = port_rdata | prt_rdata[8*k +: 8];
      port_hit_any = port_hit_any | prt_hit[k];
    end
    sfr_rdata = core_hit ? core_rdata : port_rdata;
  end
  assign sfr_hit = core_hit | port_hit_any;
endmodule // xae_xdata_ext

// File: xae_xdata_ext_checker.sv
// port assertions for the xdata extension block
`timescale 1ns/100ps
`include "xae_defs.vh"
module xae_xdata_ext_checker #(
  parameter NPORT = `XAE_NPORT
) (
  // clock and reset
  input wire        sys_clk,
  input wire        sys_rst,
  // core side
  input wire        sfr_wr,
  input wire        dptr_load,
  input wire [15:0] dptr_load_val,
  input wire        dptr_inc,
  input wire [15:0] sel_dptr,
  input wire        xmov_en,
  input wire        xmov_mode,
  input wire [7:0]  xmov_ri,
  input wire [23:0] xdata_addr,
  input wire        xdata_valid,
  // region selects
  input wire        sel_sram,
  input wire        sel_intc,
  input wire        sel_port,
  input wire        sel_eeprom,
  input wire        sel_ecc,
  input wire        sel_other
);
  // one clock domain, reset masks every check
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire [23:0] a = xdata_addr;
  wire        any_sel = sel_sram | sel_intc | sel_port | sel_eeprom | sel_ecc | sel_other;
  ////////////////////////////////////////////////////////////////////////////
  a_addr_hold: assert property (!xmov_en |=> $stable(xdata_addr) && !xdata_valid)
    else $error("address moved without a move");
  a_ptr_low: assert property (xmov_en && !xmov_mode |=> a[15:0] == $past(sel_dptr))
    else $error("pointer move low bits wrong");
  a_ri_low: assert property (xmov_en && xmov_mode |=> xdata_valid && a[7:0] == $past(xmov_ri))
    else $error("indirect move low bits wrong");
  a_ptr_load: assert property (dptr_load && !sfr_wr |=> sel_dptr == $past(dptr_load_val))
    else $error("pointer load lost");
  a_ptr_inc: assert property (dptr_inc && !dptr_load && !sfr_wr |=> sel_dptr == $past(sel_dptr) + 16'h0001)
    else $error("pointer increment wrong");
  a_sel_idle: assert property (!xdata_valid |-> !any_sel)
    else $error("region select outside a move");
  a_sram_decode: assert property (xdata_valid |-> sel_sram == (a <= `XAE_SRAM_HI))
    else $error("sram decode wrong");
  a_port_decode: assert property (xdata_valid |-> sel_port == (a >= `XAE_PORT_LO && a <= `XAE_PORT_HI))
    else $error("port decode wrong");
  a_intc_decode: assert property (xdata_valid |-> sel_intc == (a >= `XAE_INTC_LO && a <= `XAE_INTC_HI))
    else $error("intc decode wrong");
  a_eeprom_decode: assert property (xdata_valid |-> sel_eeprom == (a >= `XAE_EEP_LO && a <= `XAE_EEP_HI))
    else $error("eeprom decode wrong");
  a_ecc_decode: assert property (xdata_valid |-> sel_ecc == (a >= `XAE_ECC_LO && a <= `XAE_ECC_HI))
    else $error("ecc decode wrong");
endmodule // xae_xdata_ext_checker
bind xae_xdata_ext xae_xdata_ext_checker #(.NPORT(NPORT)) u_chk (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .sfr_wr(sfr_wr), .dptr_load(dptr_load), .dptr_load_val(dptr_load_val),
  .dptr_inc(dptr_inc), .sel_dptr(sel_dptr), .xmov_en(xmov_en), .xmov_mode(xmov_mode),
  .xmov_ri(xmov_ri), .xdata_addr(xdata_addr), .xdata_valid(xdata_valid), .sel_sram(sel_sram),
  .sel_intc(sel_intc), .sel_port(sel_port), .sel_eeprom(sel_eeprom), .sel_ecc(sel_ecc),
  .sel_other(sel_other));

// File: xae_core_model.sv
// core model: special register bus, pointer operations, xdata moves
`timescale 1ns/100ps
module xae_core_model (
  // clock
  input  wire        sys_clk,
  // special register bus
  output reg  [7:0]  sfr_addr,
  output reg         sfr_wr,
  output reg  [7:0]  sfr_wdata,
  // pointer operations and moves
  output reg         dptr_load,
  output reg  [15:0] dptr_load_val,
  output reg         dptr_inc,
  output reg         xmov_en,
  output reg         xmov_mode,
  output reg  [7:0]  xmov_ri
);
  // idle bus from time zero
  initial begin
    {sfr_addr, sfr_wr, sfr_wdata, dptr_load, dptr_load_val, dptr_inc} = 35'h0;
    {xmov_en, xmov_mode, xmov_ri} = 10'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one write; data scrambled once the strobe drops
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge sys_clk);
      {sfr_addr, sfr_wdata, sfr_wr} <= {a, d, 1'b1};
      @(posedge sys_clk);
      {sfr_wdata, sfr_wr} <= {~d, 1'b0};
    end
  endtask
  // point the read address, read data is combinational
  task point(input [7:0] a);
    @(posedge sys_clk) sfr_addr <= a;
  endtask
  // one xdata move, register value scrambled afterwards
  task mov(input m, input [7:0] ri);
    begin
      @(posedge sys_clk);
      {xmov_en, xmov_mode, xmov_ri} <= {1'b1, m, ri};
      @(posedge sys_clk);
      {xmov_en, xmov_ri} <= {1'b0, ~ri};
    end
  endtask
  // pointer load or increment
  task ptr(input ld, input inc, input [15:0] v);
    begin
      @(posedge sys_clk);
      {dptr_load, dptr_inc, dptr_load_val} <= {ld, inc, v};
      @(posedge sys_clk);
      {dptr_load, dptr_inc} <= 2'h0;
    end
  endtask
endmodule // xae_core_model

// File: test_xae_xdata_ext.sv
// self-checking bench for the xdata extension block
`timescale 1ns/100ps
`include "xae_defs.vh"
module test_xae_xdata_ext;
  reg         sys_clk, sys_rst;
  reg  [71:0] hub_port_output_data, pin_in;
  wire [71:0] pin_out;
  wire [7:0]  sfr_addr, sfr_wdata, sfr_rdata, xmov_ri;
  wire [15:0] dptr_load_val, sel_dptr;
  wire [23:0] xdata_addr;
  wire [5:0]  sel;
  wire        sfr_wr, sfr_hit, dptr_load, dptr_inc, xmov_en, xmov_mode, xdata_valid;
  integer     mismatches, samples_checked, cycles, seed, i, p;
  reg  [23:0] ad;
  reg  [15:0] v;
  reg  [7:0]  x, d, s, h;
  localparam [335:0] ADDRS = {24'h000000, 24'h001fff, 24'h002000, 24'h004400, 24'h0044ff,
    24'h005000, 24'h0051ff, 24'h005200, 24'h008000, 24'h008fff, 24'h080000, 24'h081fff,
    24'h082000, 24'h800000};
  // clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      stop_test;
    end
  end
  xae_core_model u_core (.sys_clk(sys_clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .dptr_load(dptr_load), .dptr_load_val(dptr_load_val),
    .dptr_inc(dptr_inc), .xmov_en(xmov_en), .xmov_mode(xmov_mode), .xmov_ri(xmov_ri));
  xae_xdata_ext u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .dptr_load(dptr_load), .dptr_load_val(dptr_load_val), .dptr_inc(dptr_inc),
    .sel_dptr(sel_dptr), .xmov_en(xmov_en), .xmov_mode(xmov_mode), .xmov_ri(xmov_ri),
    .xdata_addr(xdata_addr), .xdata_valid(xdata_valid), .sel_sram(sel[5]), .sel_intc(sel[4]),
    .sel_port(sel[3]), .sel_eeprom(sel[2]), .sel_ecc(sel[1]), .sel_other(sel[0]),
    .hub_port_output_data(hub_port_output_data), .pin_in(pin_in), .pin_out(pin_out));
  ////////////////////////////////////////////////////////////////////////////
  // compare one result, count it
  task chk(input [95:0] what, input [23:0] exp, input [23:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // read one special register
  task rd(input [7:0] a, output [7:0] q);
    begin
      u_core.point(a);
      #1 q = sfr_rdata;
    end
  endtask
  // expected region selects
  function [5:0] decode(input [23:0] a);
    begin
      decode[5] = a <= `XAE_SRAM_HI;
      decode[4] = a >= `XAE_INTC_LO && a <= `XAE_INTC_HI;
      decode[3] = a >= `XAE_PORT_LO && a <= `XAE_PORT_HI;
      decode[2] = a >= `XAE_EEP_LO && a <= `XAE_EEP_HI;
      decode[1] = a >= `XAE_ECC_LO && a <= `XAE_ECC_HI;
      decode[0] = decode[5:1] == 5'h0;
    end
  endfunction
  // verdict
  task stop_test;
    begin
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // main sequence
  initial begin
    {mismatches, samples_checked, cycles} = 0;
    seed = 32'hf0511554;
    {sys_rst, hub_port_output_data, pin_in} = {1'b1, 144'h0};
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 2; i = i + 1) begin
      s = i ? `XAE_SFR_PX1 : `XAE_SFR_PX0;
      rd(s, x);
      chk("ext reset", 24'h0, x);
      v = i ? 16'hffff : $random(seed);
      x = $random(seed);
      u_core.wr(`XAE_SFR_DPSEL, i);
      u_core.wr(`XAE_SFR_DPL0 + 2 * i, v[7:0]);
      u_core.wr(`XAE_SFR_DPH0 + 2 * i, v[15:8]);
      u_core.wr(s, x);
      u_core.mov(1'b0, $random(seed));
      #1 chk("ptr move", {x, v}, xdata_addr);
      chk("table ptr", v, sel_dptr);
      u_core.ptr(1'b0, 1'b1, 16'h0);
      #1 chk("ptr inc", 16'(v + 16'h1), sel_dptr);
      u_core.ptr(1'b1, 1'b0, ~v);
      #1 chk("ptr load", 16'(~v), sel_dptr);
    end
    $display("test pointers done");
    for (i = 0; i < 15; i = i + 1) begin
      ad = (i == 14) ? $random(seed) : ADDRS[24 * i +: 24];
      u_core.wr(`XAE_SFR_IHIGH, ad[23:16]);
      u_core.wr(`XAE_SFR_IMID, ad[15:8]);
      u_core.mov(1'b1, ad[7:0]);
      #1 chk("ri move", ad, xdata_addr);
      chk("region", decode(ad), sel);
    end
    $display("test decode done");
    for (p = 0; p < 9; p = p + 1) begin
      {d, s, h, x} = {$random(seed), $random(seed)};
      @(posedge sys_clk) hub_port_output_data[8 * p +: 8] <= h;
      u_core.wr(`XAE_PORT_DR_LIST >> (8 * p), d);
      u_core.wr(`XAE_PORT_SEL_LIST >> (8 * p), s);
      #1 chk("pin out", (s & d) | (~s & h), pin_out[8 * p +: 8]);
      rd(`XAE_PORT_DR_LIST >> (8 * p), v[7:0]);
      chk("out data", d, v[7:0]);
      @(posedge sys_clk) pin_in[8 * p +: 8] <= x;
      u_core.wr(`XAE_PORT_PS_LIST >> (8 * p), ~x);
      rd(`XAE_PORT_PS_LIST >> (8 * p), v[7:0]);
      chk("pin state", x, v[7:0]);
    end
    $display("test ports done");
    u_core.wr(8'hb8, 8'h5a);
    rd(8'hb8, x);
    chk("unmapped", 24'h0, {sfr_hit, x});
    $display("test unmapped done");
    stop_test;
  end
endmodule // test_xae_xdata_ext
